// [inc/shift_params.svh]
`ifndef SHIFT_PARAMS_SVH
`define SHIFT_PARAMS_SVH

// geometry of one stage and of the full chain
`define STAGE_BITS 16
`define STAGE_ADDR_BITS 4
`define STAGE_COUNT 8
`define STAGE_TOP 4'hF
`define TAP_ADDR_BITS 7
`define TOTAL_BITS 128
`define INIT_DEFAULT 16'h0000
`define INIT_ALL_DEFAULT 128'h0

// tap address masks per selected length
`define MASK_16 7'h0F
`define MASK_32 7'h1F
`define MASK_64 7'h3F
`define MASK_128 7'h7F

// wishbone register map, byte addresses
`define WB_ADR_BITS 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_COUNT 8'h08
`define REG_CONTENT0 8'h10
`define REG_CONTENT1 8'h14
`define REG_CONTENT2 8'h18
`define REG_CONTENT3 8'h1C

// control register fields
`define CTRL_WIDTH 6
`define CTRL_CLK_INV 0
`define CTRL_EN_INV 1
`define CTRL_EN_USED 2
`define CTRL_CASC_USED 3
`define CTRL_LEN_LO 4
`define CTRL_LEN_HI 5
`define CTRL_RESET 6'h3C

// status register fields
`define STAT_TAP 0
`define STAT_CASC 1
`define STAT_SHIFT_CLK 2
`define STAT_TAPSEL_LO 8
`define STAT_TAPSEL_HI 14

`define WORD_ZERO 32'h0000_0000
`define COUNT_ONE 32'h0000_0001

`endif

// [inc/shift_pkg.sv]
`include "shift_params.svh"

package shift_pkg;

    // overall chain length chosen by software
    typedef enum logic [1:0]
    {
        LEN_16 = 2'b00,
        LEN_32 = 2'b01,
        LEN_64 = 2'b10,
        LEN_128 = 2'b11
    } length_mode_t;

    typedef logic [`TAP_ADDR_BITS-1:0] tap_addr_t;
    typedef logic [31:0] word_t;
    typedef logic [`STAGE_BITS-1:0] stage_bits_t;

endpackage

// [core/cascadable_shift_stage_en.sv]
`timescale 1ns/1ns
`default_nettype none
`include "shift_params.svh"

// one 16-bit addressable stage with shift enable and cascade output
module cascadable_shift_stage_en
    import shift_pkg::*;
#(
    parameter stage_bits_t INIT = `INIT_DEFAULT // contents after configuration
)
(
    input wire logic clk_i,
    input wire logic shift_i,
    input wire logic serial_i,
    input wire logic [`STAGE_ADDR_BITS-1:0] tap_sel_i,
    output logic tap_o,
    output logic cascade_o,
    output stage_bits_t contents_o
);

    // storage starts from the configuration value and is never reset
    stage_bits_t bits_reg = INIT;
    stage_bits_t bits_next;

    // new bit enters at position zero, all others move up one place
    assign bits_next = shift_i ? {bits_reg[`STAGE_BITS-2:0], serial_i} : bits_reg;

    // one edge per shift; no reset term so a global reset leaves contents
    always_ff @(posedge clk_i)
    begin
        bits_reg <= bits_next;
    end

    // tap is a pure mux on the address, no clock involved
    assign tap_o = bits_reg[tap_sel_i];
    // last bit leaves the stage here, address has no say in it
    assign cascade_o = bits_reg[`STAGE_TOP];
    assign contents_o = bits_reg;

endmodule

`default_nettype wire

// [core/addressable_shift_register.sv]
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "shift_params.svh"

module addressable_shift_register
    import shift_pkg::*;
#(
    // configuration contents, 16 bits per stage, stage 0 in the low bits
    parameter logic [`TOTAL_BITS-1:0] INIT = `INIT_ALL_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`WB_ADR_BITS-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // user side of the shift register
    input wire logic shift_clk_i,
    input wire logic shift_enable_i,
    input wire logic serial_in_i,
    input wire tap_addr_t tap_select_i,
    output logic tap_out_o,
    output logic cascade_out_o
);

    // ------------------------------------------------------------------
    // control register and its decoded fields
    // ------------------------------------------------------------------

    logic [`CTRL_WIDTH-1:0] ctrl_reg; // software configuration
    logic [`CTRL_WIDTH-1:0] ctrl_next;
    logic clk_invert; // shift on falling edge of shift clock
    logic en_invert; // enable is active low
    logic en_used; // variant with enable pin
    logic casc_used; // variant with cascade output
    length_mode_t len_mode; // overall chain length

    assign clk_invert = ctrl_reg[`CTRL_CLK_INV];
    assign en_invert = ctrl_reg[`CTRL_EN_INV];
    assign en_used = ctrl_reg[`CTRL_EN_USED];
    assign casc_used = ctrl_reg[`CTRL_CASC_USED];
    assign len_mode = length_mode_t'(ctrl_reg[`CTRL_LEN_HI:`CTRL_LEN_LO]);

    // ------------------------------------------------------------------
    // shift edge detection
    // the shift clock is a plain synchronous input, sampled once per
    // system clock; this costs one cycle of latency but keeps a single
    // clock domain, and it lets the active edge be a software choice
    // ------------------------------------------------------------------

    logic shift_clk_prev_reg; // last sample of the shift clock
    logic rise_edge; // low to high seen this cycle
    logic fall_edge; // high to low seen this cycle
    logic active_edge; // the edge that the variant shifts on
    logic enable_level; // enable after polarity correction
    logic shift_now; // one-cycle shift command to every stage

    assign rise_edge = shift_clk_i & ~shift_clk_prev_reg;
    assign fall_edge = ~shift_clk_i & shift_clk_prev_reg;
    // pick the edge per the inversion bit
    assign active_edge = clk_invert ? fall_edge : rise_edge;
    // polarity of the enable, independent of the edge choice
    assign enable_level = shift_enable_i ^ en_invert;
    // without an enable pin the register shifts on every active edge
    assign shift_now = active_edge & (~en_used | enable_level);

    // edge history; not cleared by reset so a reset pulse cannot fake an edge
    always_ff @(posedge clk_i)
    begin
        shift_clk_prev_reg <= shift_clk_i;
    end

    // ------------------------------------------------------------------
    // stage chain: eight 16-bit stages, each after the first fed by the previous cascade
    // ------------------------------------------------------------------

    logic [`STAGE_COUNT-1:0] stage_tap; // per-stage tap outputs
    logic [`STAGE_COUNT-1:0] stage_casc; // per-stage last bits
    logic [`STAGE_COUNT-1:0] stage_in; // per-stage serial inputs
    stage_bits_t stage_bits [`STAGE_COUNT]; // contents, read back by software
    tap_addr_t tap_eff; // tap address masked to the selected length
    tap_addr_t tap_mask; // address bits that the length mode keeps

    // first stage takes the user input, the rest chain by cascade
    assign stage_in = {stage_casc[`STAGE_COUNT-2:0], serial_in_i};

    genvar gi;
    generate
        for (gi = 0; gi < `STAGE_COUNT; gi++)
        begin : g_stage
            // every stage sees the same clock and shift command
            cascadable_shift_stage_en #(
                .INIT(INIT[gi*`STAGE_BITS +: `STAGE_BITS])
            ) u_stage (
                .clk_i(clk_i),
                .shift_i(shift_now),
                .serial_i(stage_in[gi]),
                .tap_sel_i(tap_eff[`STAGE_ADDR_BITS-1:0]),
                .tap_o(stage_tap[gi]),
                .cascade_o(stage_casc[gi]),
                .contents_o(stage_bits[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // length mode decode: address width and cascade tap point
    // ------------------------------------------------------------------

    logic casc_sel; // last bit of the selected length

    always_comb
    begin
        unique case (len_mode)
            LEN_16:
            begin
                tap_mask = `MASK_16; // four address bits
                casc_sel = stage_casc[0];
            end
            LEN_32:
            begin
                tap_mask = `MASK_32;
                casc_sel = stage_casc[1];
            end
            LEN_64:
            begin
                tap_mask = `MASK_64;
                casc_sel = stage_casc[3];
            end
            LEN_128:
            begin
                tap_mask = `MASK_128;
                casc_sel = stage_casc[`STAGE_COUNT-1];
            end
        endcase
    end

    // upper address bits beyond the selected length are forced to zero
    assign tap_eff = tap_select_i & tap_mask;

    // ------------------------------------------------------------------
    // wide tap multiplexer tree, purely combinational so that a new
    // address shows immediately; a constant address and length mode make the tap a
    // fixed-length register output that only moves on shifts
    // ------------------------------------------------------------------

    logic [3:0] wide_mux_level1; // pairs of stages, steered by bit 4
    logic [1:0] wide_mux_level2; // 64-bit halves, steered by bit 5
    logic wide_mux_level3; // full register, steered by bit 6

    genvar gm;
    generate
        for (gm = 0; gm < 4; gm++)
        begin : g_level1
            assign wide_mux_level1[gm] = tap_eff[4] ? stage_tap[2*gm+1] : stage_tap[2*gm];
        end
        for (gm = 0; gm < 2; gm++)
        begin : g_level2
            assign wide_mux_level2[gm] =
                tap_eff[5] ? wide_mux_level1[2*gm+1] : wide_mux_level1[2*gm];
        end
    endgenerate

    // top bit picks between the two 64-bit halves
    assign wide_mux_level3 = tap_eff[6] ? wide_mux_level2[1] : wide_mux_level2[0];

    // tap output follows the address with no clock in the path
    assign tap_out_o = wide_mux_level3;
    // cascade output only where the variant has one; it comes from stage bits
    assign cascade_out_o = casc_used & casc_sel;

    // ------------------------------------------------------------------
    // shift counter, lets software see how many shifts were taken
    // a clear and a shift in the same cycle keeps the shift
    // ------------------------------------------------------------------

    word_t shift_count_reg; // enabled shifts since last clear
    word_t shift_count_next;

    // ------------------------------------------------------------------
    // wishbone slave decode
    // single-cycle ack: request seen in cycle 0, ack in cycle 1, ack
    // drops in cycle 2 even if the master keeps stb high
    // ------------------------------------------------------------------

    logic ack_reg; // registered acknowledge
    word_t rdata_reg; // registered read data
    word_t rdata_next;
    logic wb_req; // new request, not yet answered
    logic wb_wr; // write taken this cycle
    logic hit_ctrl; // address decodes
    logic hit_status;
    logic hit_count;
    logic hit_content0;
    logic hit_content1;
    logic hit_content2;
    logic hit_content3;
    word_t status_word; // live status view
    word_t ctrl_word; // control read back

    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wb_wr = wb_req & wb_we_i;
    assign hit_ctrl = (wb_adr_i == `REG_CTRL);
    assign hit_status = (wb_adr_i == `REG_STATUS);
    assign hit_count = (wb_adr_i == `REG_COUNT);
    assign hit_content0 = (wb_adr_i == `REG_CONTENT0);
    assign hit_content1 = (wb_adr_i == `REG_CONTENT1);
    assign hit_content2 = (wb_adr_i == `REG_CONTENT2);
    assign hit_content3 = (wb_adr_i == `REG_CONTENT3);

    // control bits all sit in byte lane 0
    assign ctrl_next = (wb_wr & hit_ctrl & wb_sel_i[0]) ?
        wb_dat_i[`CTRL_WIDTH-1:0] : ctrl_reg;

    // clear on write of any byte lane, but a same-cycle shift is counted
    assign shift_count_next = (wb_wr & hit_count & (|wb_sel_i)) ?
        (shift_now ? `COUNT_ONE : `WORD_ZERO) :
        (shift_count_reg + (shift_now ? `COUNT_ONE : `WORD_ZERO));

    assign ctrl_word = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_reg};

    // status: outputs, sampled shift clock and the raw tap address
    assign status_word = {
        {(31-`STAT_TAPSEL_HI){1'b0}},
        tap_select_i,
        {(`STAT_TAPSEL_LO-`STAT_SHIFT_CLK-1){1'b0}},
        shift_clk_prev_reg,
        cascade_out_o,
        tap_out_o
    };

    // read data mux; unmapped addresses answer with zero
    assign rdata_next =
        hit_ctrl ? ctrl_word :
        hit_status ? status_word :
        hit_count ? shift_count_reg :
        hit_content0 ? {stage_bits[1], stage_bits[0]} :
        hit_content1 ? {stage_bits[3], stage_bits[2]} :
        hit_content2 ? {stage_bits[5], stage_bits[4]} :
        hit_content3 ? {stage_bits[7], stage_bits[6]} :
        `WORD_ZERO;

    // bus state and configuration; the shift contents have no reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= `WORD_ZERO;
            ctrl_reg <= `CTRL_RESET; // rising edge, active high, all options
            shift_count_reg <= `WORD_ZERO;
        end
        else
        begin
            ack_reg <= wb_req;
            rdata_reg <= wb_req ? rdata_next : rdata_reg;
            ctrl_reg <= ctrl_next;
            shift_count_reg <= shift_count_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

endmodule

`default_nettype wire

// [testbench/addressable_shift_register_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
`include "shift_params.svh"

// watches the register port and the shift port from outside
module addressable_shift_register_asserts
    import shift_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`WB_ADR_BITS-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic shift_clk_i,
    input wire logic shift_enable_i,
    input wire logic serial_in_i,
    input wire tap_addr_t tap_select_i,
    input wire logic tap_out_o,
    input wire logic cascade_out_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [5:0] ctrl_q; // shadow of the control register
    logic sclk_q; // shift clock as sampled one edge earlier
    wire take_w = wb_cyc_i && wb_stb_i && !wb_ack_o; // request taken at this edge
    wire wr_w = take_w && wb_we_i; // any write may retune the outputs
    // active shift clock transition in the chosen direction
    wire edge_w = ctrl_q[0] ? (sclk_q && !shift_clk_i) : (!sclk_q && shift_clk_i);
    wire shift_w = edge_w && (!ctrl_q[2] || (shift_enable_i ^ ctrl_q[1]));
    // top tap address of the selected length
    wire [6:0] mask_w = {ctrl_q[5:4] == 2'h3, ctrl_q[5:4] >= 2'h2, ctrl_q[5:4] != 2'h0, 4'hF};

    // shadow follows taken control writes, needs byte lane 0
    always_ff @(posedge clk_i)
    begin
        sclk_q <= shift_clk_i;
        if (rst_i)
            ctrl_q <= `CTRL_RESET;
        else if (wr_w && wb_adr_i == `REG_CTRL && wb_sel_i[0])
            ctrl_q <= wb_dat_i[5:0];
    end

    AST_ACK_NEXT: assert property (take_w |=> wb_ack_o)
        else $error("ack missing after a taken request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_HOLD: assert property (!take_w |=> $stable(wb_dat_o))
        else $error("read data moved without a request");
    AST_CASC_HOLD: assert property (!shift_w && !wr_w |=> $stable(cascade_out_o))
        else $error("cascade moved without a shift");
    AST_TAP_HOLD: assert property (!shift_w && !wr_w |=> $stable(tap_select_i) |-> $stable(tap_out_o))
        else $error("tap moved without shift or address change");
    AST_TAP_ENTRY: assert property (shift_w && !wr_w && tap_select_i == 7'h00 |=> $stable(tap_select_i) |-> tap_out_o == $past(serial_in_i))
        else $error("serial bit not at position zero after shift");
    AST_CASC_OFF: assert property (!ctrl_q[3] |-> !cascade_out_o)
        else $error("cascade driven while unused");
    AST_TAP_TOP: assert property (ctrl_q[3] && (tap_select_i & mask_w) == mask_w |-> tap_out_o == cascade_out_o)
        else $error("top tap differs from cascade");

    cover property (shift_w);
    cover property (edge_w && !shift_w);
    cover property (wr_w && wb_adr_i == `REG_CTRL);
endmodule

bind addressable_shift_register addressable_shift_register_asserts U_AST (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .shift_clk_i(shift_clk_i), .shift_enable_i(shift_enable_i),
    .serial_in_i(serial_in_i), .tap_select_i(tap_select_i), .tap_out_o(tap_out_o),
    .cascade_out_o(cascade_out_o));
`default_nettype wire

// [testbench/shift_user_model.sv]
`timescale 1ns/1ns
`default_nettype none

// user logic on the far side of the shift port
module shift_user_model
    import shift_pkg::*;
(
    input wire logic clk_i,
    input wire logic tap_out_i,
    input wire logic cascade_out_i,
    output logic shift_clk_o,
    output logic shift_enable_o,
    output logic serial_o,
    output tap_addr_t tap_select_o,
    output logic tap_q_o,
    output logic casc_q_o
);
    int hold = 1; // cycles each level stands, raised for slow traffic

    initial
    begin
        shift_clk_o = 1'b0;
        shift_enable_o = 1'b0;
        serial_o = 1'b0;
        tap_select_o = 7'h00;
    end

    // capture of tap and cascade on the shared clock
    always_ff @(posedge clk_i)
    begin
        tap_q_o <= tap_out_i;
        casc_q_o <= cascade_out_i;
    end

    // move the shift clock to lvl with data and enable set up for that edge
    task automatic edge_to(input logic lvl, input logic d, input logic en);
        @(posedge clk_i);
        shift_clk_o <= lvl;
        serial_o <= d;
        shift_enable_o <= en;
        repeat (hold) @(posedge clk_i);
        // hold ran out: invert so a stale bit cannot pass for a good one
        serial_o <= ~d;
        shift_enable_o <= ~en;
    endtask

    // static tap address; length is address plus one
    task automatic addr(input tap_addr_t a);
        @(posedge clk_i);
        tap_select_o <= a;
    endtask
endmodule
`default_nettype wire

// [testbench/addressable_shift_register_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "shift_params.svh"

// self-checking bench: bus master plus user model on the shift port
module addressable_shift_register_tb_top;
    import shift_pkg::*;
    localparam logic [127:0] INIT_VAL = 128'hA5C3; // non-zero start contents
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_wd = 32'h0, wb_rd, rd_q;
    logic wb_ack, shift_clk, shift_en, serial, tap_out, casc, tap_q;
    logic casc_q; // cascade output as registered by the user model
    tap_addr_t tap_sel;
    tap_addr_t taps[7] = '{7'h00, 7'h04, 7'h0F, 7'h10, 7'h3F, 7'h40, 7'h7F};
    logic [127:0] exp_chain = INIT_VAL; // expected chain contents
    int exp_cnt = 0, miscompares = 0, cmp_count = 0, cycles = 0;

    always #10 clk_i = ~clk_i;

    addressable_shift_register #(.INIT(INIT_VAL)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .shift_clk_i(shift_clk), .shift_enable_i(shift_en), .serial_in_i(serial),
        .tap_select_i(tap_sel), .tap_out_o(tap_out), .cascade_out_o(casc));
    shift_user_model U_USR (.clk_i(clk_i), .tap_out_i(tap_out), .cascade_out_i(casc),
        .shift_clk_o(shift_clk), .shift_enable_o(shift_en), .serial_o(serial),
        .tap_select_o(tap_sel), .tap_q_o(tap_q), .casc_q_o(casc_q));

    // hang guard, far beyond what the sequence needs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // one classic cycle; held until ack is seen high at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wd <= d;
        wb_sel <= s;
        @(posedge clk_i);
        while (wb_ack !== 1'b1)
            @(posedge clk_i);
        rd_q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(n, e, rd_q);
    endtask

    task automatic t_content();
        for (int i = 0; i < 4; i++)
            rdc(8'h10 + 8'(4 * i), exp_chain[32 * i +: 32], "content");
        rdc(`REG_COUNT, 32'(exp_cnt), "count");
    endtask

    // address change alone, looked at mid-cycle with no shift edge
    task automatic tapc(input tap_addr_t a, input logic e);
        U_USR.addr(a);
        @(negedge clk_i);
        chk("tap_out", {31'h0, e}, {31'h0, tap_out});
    endtask

    // one full shift clock pulse; take says whether a shift is due
    task automatic sh(input logic d, input logic en, input logic take);
        U_USR.edge_to(1'b1, d, en);
        U_USR.edge_to(1'b0, d, en);
        if (take)
        begin
            exp_chain = {exp_chain[126:0], d};
            exp_cnt++;
        end
    endtask

    task automatic t_reset();
        rdc(`REG_CTRL, 32'h3C, "ctrl");
        t_content();
        for (int k = 0; k < 16; k++)
            tapc(7'(k), INIT_VAL[k]);
    endtask

    // long run across stage borders, prompt then slow far side
    task automatic t_shift();
        for (int i = 0; i < 70; i++)
        begin
            U_USR.hold = (i < 60) ? 1 : 3;
            sh(1'(i % 3 == 0 || i > 64), 1'b1, 1'b1);
        end
        U_USR.hold = 1;
        t_content();
        foreach (taps[j])
            tapc(taps[j], exp_chain[taps[j]]);
        @(negedge clk_i);
        chk("tap_q", {31'h0, exp_chain[127]}, {31'h0, tap_q});
    endtask

    // enable inactive, lane-less write dropped, polarity inverted, enable unused
    task automatic t_enable();
        sh(1'b1, 1'b0, 1'b0);
        t_content();
        bus(1'b1, `REG_CTRL, 32'h3E, 4'h0);
        sh(1'b1, 1'b0, 1'b0);
        bus(1'b1, `REG_CTRL, 32'h3E, 4'hF);
        sh(1'b0, 1'b0, 1'b1);
        sh(1'b1, 1'b1, 1'b0);
        bus(1'b1, `REG_CTRL, 32'h38, 4'h1);
        sh(1'b1, 1'b0, 1'b1);
        t_content();
    endtask

    // inverted clock: nothing on the rise, one shift on the fall
    task automatic t_edge();
        bus(1'b1, `REG_CTRL, 32'h3D, 4'h1);
        tapc(7'h00, exp_chain[0]);
        U_USR.edge_to(1'b1, ~exp_chain[0], 1'b1);
        @(negedge clk_i);
        chk("rise", {31'h0, exp_chain[0]}, {31'h0, tap_out});
        U_USR.edge_to(1'b0, ~exp_chain[0], 1'b1);
        exp_chain = {exp_chain[126:0], ~exp_chain[0]};
        exp_cnt++;
        tapc(7'h00, exp_chain[0]);
    endtask

    // each length: top tap, cascade, aliasing above the length
    task automatic t_length();
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, `REG_CTRL, 32'h0C | 32'(m << 4), 4'h1);
            tapc(7'((16 << m) - 1), exp_chain[(16 << m) - 1]);
            chk("cascade", {31'h0, exp_chain[(16 << m) - 1]}, {31'h0, casc});
            @(negedge clk_i);
            chk("casc_q", {31'h0, exp_chain[(16 << m) - 1]}, {31'h0, casc_q});
            tapc(7'(16 << m), exp_chain[0]);
        end
        bus(1'b1, `REG_CTRL, 32'h34, 4'h1);
        @(negedge clk_i);
        chk("cascade", 32'h0, {31'h0, casc});
    endtask

    // read-only and unmapped places, count clear, reset in mid-run
    task automatic t_bus();
        bus(1'b1, `REG_CONTENT0, 32'hFFFF_FFFF, 4'hF);
        rdc(8'h40, 32'h0, "unmapped");
        bus(1'b1, `REG_COUNT, 32'h0, 4'h2);
        exp_cnt = 0;
        t_content();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`REG_CTRL, 32'h3C, "ctrl");
        t_content();
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_shift();
        t_enable();
        t_edge();
        t_length();
        t_bus();
        close_out();
    end
endmodule
`default_nettype wire
